// file: design/acsp_top.sv
// Summary of operation
// - Clock low, data high as straps: sync pattern on all channels.
// - Clock high, data low as straps: global power down of everything.
// - Clock and data high as straps: deskew pattern on all channels.
// - Enable strap four levels pick reference source and coarse gain.
// - Straps configure the device automatically after power-up.
// - First config strap picks bit clock rate and wire count.
// - Second config strap picks 12x/14x and capture edge, SDR only.
// - Fourth config strap picks bit order and number format.
// - Bits sampled on shift clock falling edges while enable is low.
// - Every 16th falling edge loads the word into its register.
// - Partial word at enable release is discarded.
// - Several words may follow within one enable low period.
// - Shift clock up to 20 MHz, any slower rate or duty cycle.
// - Word is 5 address bits then 11 data bits.
// - Reset pin high pulse over 10 ns resets all registers.
// - Soft reset bit in register 0x00 clears all, then self-clears.
// - Register write takes effect about 100 ns after 16th edge.
// - Override bit in 0x0D hands strap modes to the registers.
// - Power-down pin high forces global power down over register.
// - After any reset every register bit reads zero.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module acsp_top #(
   parameter logic [13:0] SYNC_PATTERN   = 14'h0000,
   parameter logic [13:0] DESKEW_PATTERN = 14'h0000
) (
   // Clock and reset
   input  wire logic                              clk_in,
   input  wire logic                              rstn_in,
   // Serial port pins
   input  wire logic                              serial_enable_n_in,
   input  wire logic                              serial_clock_in,
   input  wire logic                              serial_in_line_in,
   input  wire logic                              hw_reset_in,
   // Strap pins, level codes from the comparators
   input  wire logic [1:0]                        serial_enable_level_in,
   input  wire logic                              powerdown_strap_in,
   input  wire logic [1:0]                        wire_clock_strap_in,
   input  wire logic [1:0]                        serialize_edge_strap_in,
   input  wire logic [1:0]                        reserved_strap_in,
   input  wire logic [1:0]                        order_format_strap_in,
   // Software port
   input  wire logic [acsp_pkg::BUS_ADDR_W-1:0]   bus_addr_in,
   input  wire logic [31:0]                       bus_wdata_in,
   input  wire logic                              bus_wr_in,
   input  wire logic                              bus_rd_in,
   output logic      [31:0]                       bus_rdata_out,
   // Operating modes
   output acsp_pkg::acsp_pattern_t                test_pattern_out,
   output logic      [13:0]                       pattern_word_out,
   output logic                                   global_pd_out,
   output logic      [3:0]                        chan_pd_out,
   output logic                                   ref_internal_out,
   output logic                                   coarse_gain_out,
   output logic                                   two_wire_out,
   output logic                                   ddr_clock_out,
   output logic                                   serialize14_out,
   output logic                                   capture_rising_out,
   output logic                                   lsb_first_out,
   output logic                                   offset_binary_out,
   output logic                                   bytewise_out
);
   localparam int unsigned SW = 15;
   localparam int unsigned DW = acsp_pkg::DLY_W;
   localparam logic [DW-1:0] DLY_LAST = DW'(acsp_pkg::WRITE_DELAY_CYC - 1);
   // Sync shows reset zeros for two edges, so boot capture waits them out
   localparam logic [1:0] BOOT_WAIT = 2'h3;

   logic [SW-1:0] pins_s;
   logic          sen_s;
   logic          sclk_s;
   logic          serial_in_line_s;
   logic          rst_s;
   logic          pdn_s;
   logic [1:0]    sen_lvl_s;
   logic [7:0]    cfg_s;

   // Serial, reset and strap pins cross into clk_in through two flops; the software port does not
   acsp_sync #(.W(SW)) u_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    ({serial_enable_n_in, serial_clock_in, serial_in_line_in,
                 hw_reset_in, powerdown_strap_in, serial_enable_level_in,
                 wire_clock_strap_in, serialize_edge_strap_in,
                 reserved_strap_in, order_format_strap_in}),
      .q_out   (pins_s)
   );
   assign {sen_s, sclk_s, serial_in_line_s, rst_s, pdn_s, sen_lvl_s, cfg_s} = pins_s;

   // Reset pin held high means the serial pins act as straps
   logic strap_mode;
   assign strap_mode = rst_s;

   // Serial shifter and delayed write
   logic                          sclk_prev_q, sclk_prev_d;
   logic [acsp_pkg::WORD_W-1:0]   shift_q, shift_d;
   logic [acsp_pkg::CNT_W-1:0]    cnt_q, cnt_d;
   logic                          pend_q, pend_d;
   logic [acsp_pkg::WORD_W-1:0]   pword_q, pword_d;
   logic [acsp_pkg::DLY_W-1:0]    dly_q, dly_d;
   logic                          fall;
   logic                          wr_go;
   logic [acsp_pkg::WORD_W-1:0]   next_word;

   // Falling edge found from the synced clock; 20 MHz gives 10 samples
   assign fall      = sclk_prev_q & ~sclk_s;
   assign next_word = {shift_q[acsp_pkg::WORD_W-2:0], serial_in_line_s};

   always_comb begin
      sclk_prev_d = sclk_s;
      shift_d     = shift_q;
      cnt_d       = cnt_q;
      pend_d      = pend_q;
      pword_d     = pword_q;
      dly_d       = dly_q;
      wr_go       = 1'b0;
      if (pend_q) begin
         if (dly_q == DLY_LAST) begin
            wr_go  = 1'b1;
            pend_d = 1'b0;
         end else begin
            dly_d = dly_q + 1'b1;
         end
      end
      if (sen_s || strap_mode) begin
         cnt_d = '0;
      end else if (fall) begin
         shift_d = next_word;
         cnt_d   = cnt_q + 1'b1;
         if (cnt_q == {acsp_pkg::CNT_W{1'b1}}) begin
            pend_d  = 1'b1;
            pword_d = next_word;
            dly_d   = '0;
         end
      end
      if (rst_s) begin
         pend_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sclk_prev_q <= 1'b0;
         shift_q     <= '0;
         cnt_q       <= '0;
         pend_q      <= 1'b0;
         pword_q     <= '0;
         dly_q       <= '0;
      end else begin
         sclk_prev_q <= sclk_prev_d;
         shift_q     <= shift_d;
         cnt_q       <= cnt_d;
         pend_q      <= pend_d;
         pword_q     <= pword_d;
         dly_q       <= dly_d;
      end
   end

   // Register file
   logic [acsp_pkg::DATA_W-1:0] regs_q [acsp_pkg::NUM_REG];
   logic [acsp_pkg::DATA_W-1:0] regs_d [acsp_pkg::NUM_REG];
   logic [acsp_pkg::ADDR_W-1:0] w_addr;
   logic [acsp_pkg::DATA_W-1:0] w_data;
   assign {w_addr, w_data} = pword_q;

   always_comb begin
      regs_d = regs_q;
      if (rst_s) begin
         for (int i = 0; i < acsp_pkg::NUM_REG; i++) begin
            regs_d[i] = '0;
         end
      end else if (wr_go) begin
         if (w_addr == acsp_pkg::REG_MAIN &&
             w_data[acsp_pkg::BIT_SOFT_RST]) begin
            // Bit is never stored, so it reads back zero
            for (int i = 0; i < acsp_pkg::NUM_REG; i++) begin
               regs_d[i] = '0;
            end
         end else begin
            regs_d[w_addr] = w_data;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < acsp_pkg::NUM_REG; i++) begin
            regs_q[i] <= '0;
         end
      end else begin
         regs_q <= regs_d;
      end
   end

   // Strap capture: at power-up, or again on software request
   logic       cap_pend_q, cap_pend_d;
   logic [1:0] boot_q, boot_d;
   logic [9:0] straps_q, straps_d;
   logic       recapture;
   assign recapture = bus_wr_in && bus_addr_in == acsp_pkg::BUS_CTRL &&
                      bus_wdata_in[acsp_pkg::CTRL_RECAPTURE];

   always_comb begin
      cap_pend_d = recapture;
      boot_d     = boot_q;
      straps_d   = straps_q;
      if (boot_q != '0) begin
         boot_d = boot_q - 1'b1;
      end
      if (cap_pend_q || boot_q != '0) begin
         straps_d = {sen_lvl_s, cfg_s};
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cap_pend_q <= 1'b1;
         boot_q     <= BOOT_WAIT;
         straps_q   <= '0;
      end else begin
         cap_pend_q <= cap_pend_d;
         boot_q     <= boot_d;
         straps_q   <= straps_d;
      end
   end

   // Mode decode
   acsp_pkg::acsp_level_t lv_sen, lv_c1, lv_c2, lv_c4;
   assign lv_sen = acsp_pkg::acsp_level_t'(straps_q[9:8]);
   assign lv_c1  = acsp_pkg::acsp_level_t'(straps_q[7:6]);
   assign lv_c2  = acsp_pkg::acsp_level_t'(straps_q[5:4]);
   assign lv_c4  = acsp_pkg::acsp_level_t'(straps_q[1:0]);
   // Third strap (straps_q[3:2]) has no function; only shown in status

   logic [acsp_pkg::DATA_W-1:0] r_main, r_pat, r_out;
   logic                         ovrd;
   assign r_main = regs_q[acsp_pkg::REG_MAIN];
   assign r_pat  = regs_q[acsp_pkg::REG_PATTERN];
   assign r_out  = regs_q[acsp_pkg::REG_OUTCFG];
   assign ovrd   = r_out[acsp_pkg::BIT_OVERRIDE];

   acsp_pkg::acsp_pattern_t pat_d;
   logic gpd_d, ref_d, gain_d, two_d, ddr_d, s14_d, rise_d, lsb_d, ob_d, bw_d;
   logic [3:0] chpd_d;
   logic s_two, s_ddr, s_s14, s_rise, s_lsb, s_ob;

   always_comb begin
      s_two  = lv_c1 != acsp_pkg::ACSP_LVL_GND &&
               lv_c1 != acsp_pkg::ACSP_LVL_LOW;
      s_ddr  = lv_c1 != acsp_pkg::ACSP_LVL_HIGH;
      s_s14  = lv_c2 == acsp_pkg::ACSP_LVL_LOW ||
               lv_c2 == acsp_pkg::ACSP_LVL_HIGH;
      s_rise = lv_c2 == acsp_pkg::ACSP_LVL_HIGH ||
               lv_c2 == acsp_pkg::ACSP_LVL_FULL;
      s_lsb  = lv_c4 == acsp_pkg::ACSP_LVL_HIGH ||
               lv_c4 == acsp_pkg::ACSP_LVL_FULL;
      s_ob   = lv_c4 == acsp_pkg::ACSP_LVL_LOW ||
               lv_c4 == acsp_pkg::ACSP_LVL_HIGH;
      pat_d  = acsp_pkg::ACSP_PAT_NORMAL;
      gpd_d  = pdn_s;
      chpd_d = r_main[acsp_pkg::BIT_CH_PD_LO +: 4];
      ref_d  = r_main[acsp_pkg::BIT_REF_INT];
      gain_d = 1'b0;
      if (strap_mode) begin
         chpd_d = '0;
         ref_d  = lv_sen == acsp_pkg::ACSP_LVL_HIGH ||
                  lv_sen == acsp_pkg::ACSP_LVL_FULL;
         gain_d = lv_sen == acsp_pkg::ACSP_LVL_LOW ||
                  lv_sen == acsp_pkg::ACSP_LVL_HIGH;
         if (!sclk_s && serial_in_line_s) begin
            pat_d = acsp_pkg::ACSP_PAT_SYNC;
         end else if (sclk_s && !serial_in_line_s) begin
            gpd_d = 1'b1;
         end else if (sclk_s && serial_in_line_s) begin
            pat_d = acsp_pkg::ACSP_PAT_DESKEW;
         end
      end else begin
         gpd_d = pdn_s | r_main[acsp_pkg::BIT_GLOBAL_PD];
         if (r_pat[acsp_pkg::BIT_PAT_LO +: 3] == acsp_pkg::PAT_CODE_SYNC) begin
            pat_d = acsp_pkg::ACSP_PAT_SYNC;
         end else if (r_pat[acsp_pkg::BIT_PAT_LO +: 3] ==
                      acsp_pkg::PAT_CODE_DESKEW) begin
            pat_d = acsp_pkg::ACSP_PAT_DESKEW;
         end
         if (ovrd) begin
            gain_d = r_out[acsp_pkg::BIT_COARSE];
         end
      end
      if (ovrd && !strap_mode) begin
         two_d = r_out[acsp_pkg::BIT_TWO_WIRE];
         ddr_d = r_out[acsp_pkg::BIT_DDR];
         s14_d = r_out[acsp_pkg::BIT_SER14];
         rise_d = r_out[acsp_pkg::BIT_RISING];
         lsb_d = r_out[acsp_pkg::BIT_LSB_FIRST];
         ob_d  = r_pat[acsp_pkg::BIT_OFFSET_BIN];
         bw_d  = r_out[acsp_pkg::BIT_BYTEWISE];
      end else begin
         two_d = s_two;
         ddr_d = s_ddr;
         s14_d = s_s14;
         rise_d = s_rise;
         lsb_d = s_lsb;
         ob_d  = s_ob;
         bw_d  = 1'b0;
      end
      // Capture edge only means something with a single-rate clock
      rise_d = rise_d & ~ddr_d;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         test_pattern_out   <= acsp_pkg::ACSP_PAT_NORMAL;
         pattern_word_out   <= '0;
         global_pd_out      <= 1'b0;
         chan_pd_out        <= '0;
         ref_internal_out   <= 1'b0;
         coarse_gain_out    <= 1'b0;
         two_wire_out       <= 1'b0;
         ddr_clock_out      <= 1'b0;
         serialize14_out    <= 1'b0;
         capture_rising_out <= 1'b0;
         lsb_first_out      <= 1'b0;
         offset_binary_out  <= 1'b0;
         bytewise_out       <= 1'b0;
      end else begin
         test_pattern_out   <= pat_d;
         pattern_word_out   <= (pat_d == acsp_pkg::ACSP_PAT_SYNC) ?
                               SYNC_PATTERN : DESKEW_PATTERN;
         global_pd_out      <= gpd_d;
         chan_pd_out        <= chpd_d;
         ref_internal_out   <= ref_d;
         coarse_gain_out    <= gain_d;
         two_wire_out       <= two_d;
         ddr_clock_out      <= ddr_d;
         serialize14_out    <= s14_d;
         capture_rising_out <= rise_d;
         lsb_first_out      <= lsb_d;
         offset_binary_out  <= ob_d;
         bytewise_out       <= bw_d;
      end
   end

   // Software read port, data one cycle after the strobe
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = '0;
      if (bus_rd_in) begin
         if (bus_addr_in <= acsp_pkg::BUS_REG_LAST) begin
            rdata_d[acsp_pkg::DATA_W-1:0] =
               regs_q[bus_addr_in[acsp_pkg::ADDR_W-1:0]];
         end else if (bus_addr_in == acsp_pkg::BUS_STATUS) begin
            rdata_d[acsp_pkg::ST_PENDING]    = pend_q;
            rdata_d[acsp_pkg::ST_STRAP_MODE] = strap_mode;
            rdata_d[acsp_pkg::ST_STRAPS_LO +: 10] = straps_q;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bus_rdata_out <= '0;
      end else begin
         bus_rdata_out <= rdata_d;
      end
   end

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   enable_discard_a: assert property (sen_s |=> cnt_q == '0)
      else $error("partial word not discarded");
   fall_shift_a: assert property (fall && !sen_s && !strap_mode |=>
      shift_q[0] == $past(serial_in_line_s))
      else $error("bit not sampled on falling edge");
   word_done_a: assert property (fall && !sen_s && !strap_mode && !rst_s &&
      cnt_q == 4'hF |=> pend_q && pword_q == $past(next_word))
      else $error("16th edge did not load word");
   write_delay_a: assert property ($rose(pend_q) |->
      !wr_go [*8] ##[12:13] wr_go)
      else $error("write not about 100 ns after last edge");
   soft_reset_a: assert property (wr_go && !rst_s &&
      w_addr == acsp_pkg::REG_MAIN && w_data[acsp_pkg::BIT_SOFT_RST] |=>
      regs_q[0] == '0 && regs_q[13] == '0)
      else $error("soft reset left register set");
   hw_reset_a: assert property (rst_s |=>
      regs_q[0] == '0 && regs_q[10] == '0 && regs_q[13] == '0)
      else $error("reset pin did not clear registers");
   pdn_force_a: assert property (pdn_s |=> global_pd_out)
      else $error("power-down pin not forcing power down");
   strap_pd_a: assert property (strap_mode && sclk_s && !serial_in_line_s |=>
      global_pd_out && test_pattern_out == acsp_pkg::ACSP_PAT_NORMAL)
      else $error("strap power down not decoded");
   strap_sync_a: assert property (strap_mode && !sclk_s && serial_in_line_s |=>
      test_pattern_out == acsp_pkg::ACSP_PAT_SYNC)
      else $error("strap sync pattern not decoded");
   strap_order_a: assert property (!ovrd |=>
      lsb_first_out == $past(s_lsb) && offset_binary_out == $past(s_ob))
      else $error("strap order and format not applied");

   word_written_c: cover property (wr_go && !rst_s);
   partial_drop_c: cover property (cnt_q != '0 ##1 cnt_q == '0 && !pend_q);
   soft_reset_c: cover property (wr_go && w_data[acsp_pkg::BIT_SOFT_RST] &&
      w_addr == acsp_pkg::REG_MAIN);
endmodule // acsp_top

// file: design/acsp_pkg.sv
package acsp_pkg;

   // Serial word layout: address first, then data, MSB first
   localparam int unsigned ADDR_W  = 5;
   localparam int unsigned DATA_W  = 11;
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned CNT_W   = 4;
   localparam int unsigned NUM_REG = 32;

   // Serial register addresses
   localparam logic [ADDR_W-1:0] REG_MAIN    = 5'h00;
   localparam logic [ADDR_W-1:0] REG_PATTERN = 5'h0A;
   localparam logic [ADDR_W-1:0] REG_OUTCFG  = 5'h0D;

   // Register 0x00 fields
   localparam int unsigned BIT_SOFT_RST  = 10;
   localparam int unsigned BIT_REF_INT   = 5;
   localparam int unsigned BIT_CH_PD_LO  = 1;
   localparam int unsigned BIT_GLOBAL_PD = 0;
   // Register 0x0A fields
   localparam int unsigned BIT_OFFSET_BIN = 9;
   localparam int unsigned BIT_PAT_LO     = 5;
   localparam logic [2:0]  PAT_CODE_SYNC   = 3'h1;
   localparam logic [2:0]  PAT_CODE_DESKEW = 3'h2;
   // Register 0x0D fields
   localparam int unsigned BIT_OVERRIDE  = 10;
   localparam int unsigned BIT_BYTEWISE  = 7;
   localparam int unsigned BIT_LSB_FIRST = 6;
   localparam int unsigned BIT_COARSE    = 5;
   localparam int unsigned BIT_RISING    = 4;
   localparam int unsigned BIT_SER14     = 2;
   localparam int unsigned BIT_DDR       = 1;
   localparam int unsigned BIT_TWO_WIRE  = 0;

   // Timing
   localparam int unsigned CLK_PERIOD_NS  = 5;
   localparam int unsigned WRITE_DELAY_NS = 100;
   localparam int unsigned WRITE_DELAY_CYC =
      (WRITE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
      WRITE_DELAY_NS / CLK_PERIOD_NS;
   localparam int unsigned DLY_W = 5;

   // Software port map
   localparam int unsigned BUS_ADDR_W = 6;
   localparam logic [BUS_ADDR_W-1:0] BUS_REG_LAST = 6'h1F;
   localparam logic [BUS_ADDR_W-1:0] BUS_STATUS   = 6'h20;
   localparam logic [BUS_ADDR_W-1:0] BUS_CTRL     = 6'h21;
   localparam int unsigned CTRL_RECAPTURE = 0;
   localparam int unsigned ST_PENDING     = 0;
   localparam int unsigned ST_STRAP_MODE  = 1;
   localparam int unsigned ST_STRAPS_LO   = 2;

   // Strap voltage levels, lowest first
   typedef enum logic [1:0] {
      ACSP_LVL_GND,
      ACSP_LVL_LOW,
      ACSP_LVL_HIGH,
      ACSP_LVL_FULL
   } acsp_level_t;

   typedef enum logic [1:0] {
      ACSP_PAT_NORMAL,
      ACSP_PAT_SYNC,
      ACSP_PAT_DESKEW
   } acsp_pattern_t;

endpackage

// file: design/acsp_sync.sv
`timescale 1ns/100ps
module acsp_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // Data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   always_comb begin
      meta_d = d_in;
      q_d    = meta_q;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_q <= '0;
         q_out  <= '0;
      end else begin
         meta_q <= meta_d;
         q_out  <= q_d;
      end
   end
endmodule // acsp_sync

// file: dv/acsp_host_model.sv
`timescale 1ns/100ps
module acsp_host_model (
   // Clock
   input  wire logic clk_in,
   // Serial pins
   output logic      sen_n_out,
   output logic      sclk_out,
   output logic      serial_in_line_out
);
   initial begin
      sen_n_out = 1'b1;
      sclk_out  = 1'b0;
      serial_in_line_out = 1'b0;
   end
   task automatic half();
      repeat (16) @(posedge clk_in);
   endtask
   // Pins double as straps between frames
   task automatic strap(input logic c, input logic d);
      @(posedge clk_in);
      sclk_out  <= c;
      serial_in_line_out <= d;
   endtask
   // 80 ns halves keep the shift clock under 20 MHz
   task automatic send(input logic [47:0] w, input int n);
      @(posedge clk_in);
      sen_n_out <= 1'b0;
      half();
      for (int i = 0; i < n; i++) begin
         serial_in_line_out <= w[47-i];
         sclk_out  <= 1'b1;
         half();
         sclk_out  <= 1'b0;
         half();
      end
      sen_n_out <= 1'b1;
      serial_in_line_out <= ~serial_in_line_out; // Released line shows no stale bit
   endtask
endmodule // acsp_host_model

// file: dv/tb_acsp_top.sv
`timescale 1ns/100ps
module tb_acsp_top;
   logic clk_in, rstn_in, serial_enable_n_in, serial_clock_in;
   logic serial_in_line_in, hw_reset_in, powerdown_strap_in;
   logic bus_wr_in, bus_rd_in, global_pd_out, ref_internal_out;
   logic coarse_gain_out, two_wire_out, ddr_clock_out, serialize14_out;
   logic capture_rising_out, lsb_first_out, offset_binary_out;
   logic bytewise_out;
   logic [1:0] serial_enable_level_in, wire_clock_strap_in;
   logic [1:0] serialize_edge_strap_in, reserved_strap_in;
   logic [1:0] order_format_strap_in;
   logic [5:0] bus_addr_in;
   logic [31:0] bus_wdata_in, bus_rdata_out;
   logic [13:0] pattern_word_out;
   logic [3:0] chan_pd_out;
   acsp_pkg::acsp_pattern_t test_pattern_out;
   int errors, checks_done;
   acsp_top #(.SYNC_PATTERN(14'h1234), .DESKEW_PATTERN(14'h2BCD)) u_dut (
      .clk_in, .rstn_in, .serial_enable_n_in,
      .serial_clock_in, .serial_in_line_in, .hw_reset_in,
      .serial_enable_level_in, .powerdown_strap_in, .wire_clock_strap_in,
      .serialize_edge_strap_in, .reserved_strap_in, .order_format_strap_in,
      .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_rdata_out,
      .test_pattern_out, .pattern_word_out, .global_pd_out, .chan_pd_out,
      .ref_internal_out, .coarse_gain_out, .two_wire_out, .ddr_clock_out,
      .serialize14_out, .capture_rising_out, .lsb_first_out,
      .offset_binary_out, .bytewise_out);
   acsp_host_model u_host (.clk_in, .sen_n_out(serial_enable_n_in),
      .sclk_out(serial_clock_in), .serial_in_line_out(serial_in_line_in));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus_addr_in  <= a;
      bus_wdata_in <= d;
      bus_wr_in    <= 1'b1;
      @(posedge clk_in);
      bus_wr_in <= 1'b0;
   endtask
   task automatic bus_rd(input logic [5:0] a, input logic [31:0] e);
      @(posedge clk_in);
      bus_addr_in <= a;
      bus_rd_in   <= 1'b1;
      @(posedge clk_in);
      bus_rd_in <= 1'b0;
      #1 chk("bus_rdata", e, bus_rdata_out);
   endtask
   task automatic final_report();
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic t_straps();
      cyc(6);
      chk("ddr", 0, ddr_clock_out);
      chk("wire2", 1, two_wire_out);
      for (int i = 0; i < 4; i++) begin
         u_host.strap(i[1], i[0]);
         serial_enable_level_in  <= i[1:0];
         wire_clock_strap_in     <= i[1:0];
         serialize_edge_strap_in <= i[1:0];
         order_format_strap_in   <= i[1:0];
         cyc(4);
         bus_wr(acsp_pkg::BUS_CTRL, 32'h0000_0001);
         cyc(8);
         if (i != 2)
            chk("pattern", i == 1 ? 1 : i == 3 ? 2 : 0, test_pattern_out);
         chk("gpd", i == 2, global_pd_out);
         chk("ref", 4'b1100 >> i & 1, ref_internal_out);
         chk("gain", 4'b0110 >> i & 1, coarse_gain_out);
         chk("wire2", 4'b1100 >> i & 1, two_wire_out);
         chk("ddr", 4'b1011 >> i & 1, ddr_clock_out);
         chk("ser14", 4'b0110 >> i & 1, serialize14_out);
         chk("rise", 4'b0100 >> i & 1, capture_rising_out);
         chk("lsb", 4'b1100 >> i & 1, lsb_first_out);
         chk("obin", 4'b0110 >> i & 1, offset_binary_out);
         chk("pword", i == 1 ? 14'h1234 : 14'h2BCD, pattern_word_out);
      end
      bus_rd(acsp_pkg::BUS_STATUS, 32'h0000_0FCE);
      u_host.strap(1'b0, 1'b0);
      serial_enable_level_in  <= 2'h0;
      wire_clock_strap_in     <= 2'h0;
      serialize_edge_strap_in <= 2'h0;
      order_format_strap_in   <= 2'h0;
      hw_reset_in <= 1'b0; // Ends strap mode, low after except for the pulse in t_hwrst
      cyc(4);
      bus_wr(acsp_pkg::BUS_CTRL, 32'h0000_0001);
      cyc(8);
   endtask
   task automatic t_serial();
      u_host.send({16'h6C45, 32'h0}, 16);
      chk("wire2", 0, two_wire_out);
      cyc(20);
      chk("wire2", 1, two_wire_out);
      chk("ser14", 1, serialize14_out);
      chk("lsb", 1, lsb_first_out);
      chk("ddr", 0, ddr_clock_out);
      bus_wr(6'h0D, 32'h0000_0000);
      bus_rd(6'h0D, 32'h0000_0445);
      bus_rd(6'h3F, 32'h0000_0000);
   endtask
   task automatic t_multi();
      // Trailing 7 bits aim at 0x0D and must be dropped
      u_host.send({16'h5020, 16'h0003, 16'h6FFF}, 39);
      cyc(30);
      chk("pattern", 1, test_pattern_out);
      chk("gpd", 1, global_pd_out);
      chk("chpd", 4'h1, chan_pd_out);
      bus_rd(6'h0D, 32'h0000_0445);
      bus_rd(6'h0A, 32'h0000_0020);
      bus_rd(6'h00, 32'h0000_0003);
   endtask
   task automatic t_pdn();
      u_host.send({16'h0000, 32'h0}, 16);
      cyc(30);
      chk("gpd", 0, global_pd_out);
      @(posedge clk_in);
      powerdown_strap_in <= 1'b1;
      cyc(6);
      chk("gpd", 1, global_pd_out);
      @(posedge clk_in);
      powerdown_strap_in <= 1'b0;
      cyc(6);
      chk("gpd", 0, global_pd_out);
   endtask
   task automatic t_soft();
      u_host.send({16'h0400, 32'h0}, 16);
      cyc(30);
      bus_rd(6'h00, 32'h0000_0000);
      bus_rd(6'h0D, 32'h0000_0000);
      chk("ddr", 1, ddr_clock_out);
   endtask
   task automatic t_hwrst();
      u_host.send({16'h6CC5, 32'h0}, 16);
      cyc(30);
      bus_rd(6'h0D, 32'h0000_04C5);
      chk("bytew", 1, bytewise_out);
      @(posedge clk_in);
      hw_reset_in <= 1'b1;
      cyc(2);
      @(posedge clk_in);
      hw_reset_in <= 1'b0;
      cyc(6);
      bus_rd(6'h0D, 32'h0000_0000);
      chk("bytew", 0, bytewise_out);
   endtask
   initial begin
      errors = 0;
      checks_done = 0;
      rstn_in = 1'b0;
      hw_reset_in = 1'b1;
      powerdown_strap_in = 1'b0;
      bus_wr_in = 1'b0;
      bus_rd_in = 1'b0;
      bus_addr_in = '0;
      bus_wdata_in = '0;
      serial_enable_level_in = '0;
      wire_clock_strap_in = 2'h2;
      serialize_edge_strap_in = '0;
      reserved_strap_in = '0;
      order_format_strap_in = '0;
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      t_straps();
      t_serial();
      t_multi();
      t_pdn();
      t_soft();
      t_hwrst();
      final_report();
   end
   initial begin
      repeat (100000) @(posedge clk_in);
      errors++;
      final_report();
   end
endmodule // tb_acsp_top
